// >>> rtl/aad_core.sv
// accumulator add (direct) and add-with-carry (indirect) execution unit
//
// How it works
// - opcode 25h: direct add, two bytes
// - direct add reads any address, one cycle
// - sum replaces the accumulator
// - update carry, aux, overflow, parity; keep rest
// - 0011011r: indirect add-with-carry via r0/r1
// - indirect add uses pointed byte plus carry
//
// Implementation choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
`include "aad_consts.svh"

module aad_core (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // avalon-mm slave
   input  wire logic [10:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // architectural state
   output logic      [7:0]  acc_out,
   output logic      [7:0]  program_status_word_out
);

   aad_pkg::aad_byte_t acc_q;
   aad_pkg::aad_byte_t stw_q;
   aad_pkg::aad_byte_t ptr0_q;
   aad_pkg::aad_byte_t ptr1_q;
   logic [15:0]        instr_q;
   logic               illegal_q;
   logic               done_q;
   logic               wait_q;
   logic [31:0]        rdata_q;
   aad_pkg::aad_byte_t mem_q [256];

   // bus handshake: waitrequest drops for exactly one cycle per request
   logic req;
   logic fin;
   logic wr_fin;
   logic mem_hit;
   logic [7:0] mem_idx;

   assign req     = avs_read | avs_write;
   assign fin     = req & ~wait_q;
   assign wr_fin  = fin & avs_write;
   assign mem_hit = avs_address[10];
   assign mem_idx = avs_address[9:2];

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wait_q <= 1'b1;
      end else if (!wait_q) begin
         wait_q <= 1'b1;
      end else if (req) begin
         wait_q <= 1'b0;
      end
   end

   // execution is launched by the write to the instruction register
   logic exec;
   aad_pkg::aad_op_t op;
   logic [7:0]  opc;
   logic [7:0]  operand;
   logic [7:0]  ind_addr;
   logic        cin;
   logic [4:0]  lo_sum;
   logic [8:0]  sum9;
   logic [7:0]  res;
   logic        ovf;

   assign exec = wr_fin & ~mem_hit & (avs_address == `AAD_OFS_INSTR);
   assign opc  = avs_writedata[7:0];

   always_comb begin
      if (opc == `AAD_OP_ADD_DIR) begin
         op = aad_pkg::AAD_OP_DIRECT;
      end else if (opc[7:1] == `AAD_OP_ADC_IND) begin
         op = aad_pkg::AAD_OP_INDIRECT;
      end else begin
         op = aad_pkg::AAD_OP_NONE;
      end
   end

   // bit 0 of the opcode picks the pointer register
   assign ind_addr = opc[0] ? ptr1_q : ptr0_q;

   always_comb begin
      cin     = 1'b0;
      operand = `AAD_RST_BYTE;
      unique case (op)
         aad_pkg::AAD_OP_DIRECT: begin
            // second byte is the direct address, sfr region included
            operand = mem_q[avs_writedata[15:8]];
         end
         aad_pkg::AAD_OP_INDIRECT: begin
            operand = mem_q[ind_addr];
            cin     = stw_q[`AAD_SW_CARRY];
         end
         aad_pkg::AAD_OP_NONE: begin
            cin     = 1'b0;
         end
      endcase
   end

   assign lo_sum = {1'b0, acc_q[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
   assign sum9   = {1'b0, acc_q} + {1'b0, operand} + {8'h00, cin};
   assign res    = sum9[7:0];
   // signed overflow: like-signed operands give an unlike-signed result
   assign ovf    = (acc_q[7] == operand[7]) & (res[7] != acc_q[7]);

   // accumulator
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         acc_q <= `AAD_RST_BYTE;
      end else if (exec && op != aad_pkg::AAD_OP_NONE) begin
         acc_q <= res;
      end else if (wr_fin && !mem_hit && avs_address == `AAD_OFS_ACC) begin
         acc_q <= avs_writedata[7:0];
      end
   end

   // program status word; bank select and user flags never touched by adds
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         stw_q <= `AAD_RST_BYTE;
      end else if (exec && op != aad_pkg::AAD_OP_NONE) begin
         stw_q[`AAD_SW_CARRY]  <= sum9[8];
         stw_q[`AAD_SW_AUX]    <= lo_sum[4];
         stw_q[`AAD_SW_OVFL]   <= ovf;
         stw_q[`AAD_SW_PARITY] <= ^res;
      end else if (wr_fin && !mem_hit && avs_address == `AAD_OFS_STW) begin
         stw_q <= avs_writedata[7:0];
      end
   end

   // pointer working registers and the last instruction
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ptr0_q  <= `AAD_RST_BYTE;
         ptr1_q  <= `AAD_RST_BYTE;
         instr_q <= `AAD_RST_INSTR;
      end else if (wr_fin && !mem_hit) begin
         if (avs_address == `AAD_OFS_PTR0) begin
            ptr0_q <= avs_writedata[7:0];
         end
         if (avs_address == `AAD_OFS_PTR1) begin
            ptr1_q <= avs_writedata[7:0];
         end
         if (exec) begin
            instr_q <= avs_writedata[15:0];
         end
      end
   end

   // status: sticky illegal flag, write one to clear; a new error wins
   logic st_clr;
   assign st_clr = wr_fin & ~mem_hit & (avs_address == `AAD_OFS_STATUS);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         illegal_q <= 1'b0;
         done_q    <= 1'b0;
      end else begin
         if (exec && op == aad_pkg::AAD_OP_NONE) begin
            illegal_q <= 1'b1;
         end else if (st_clr && avs_writedata[`AAD_ST_ILLEGAL]) begin
            illegal_q <= 1'b0;
         end
         if (exec && op != aad_pkg::AAD_OP_NONE) begin
            done_q <= 1'b1;
         end else if (st_clr && avs_writedata[`AAD_ST_DONE]) begin
            done_q <= 1'b0;
         end
      end
   end

   // internal data memory, one word slot per byte
   genvar gi;
   generate
      for (gi = 0; gi < 256; gi++) begin : g_mem
         always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
               mem_q[gi] <= `AAD_RST_BYTE;
            end else if (wr_fin && mem_hit && mem_idx == 8'(gi)) begin
               mem_q[gi] <= avs_writedata[7:0];
            end
         end
      end
   endgenerate

   // read data, registered when waitrequest drops; unmapped reads zero
   logic [31:0] rmux;
   always_comb begin
      rmux = `AAD_RST_WORD;
      if (mem_hit) begin
         rmux[7:0] = mem_q[mem_idx];
      end else begin
         unique case (avs_address)
            `AAD_OFS_ACC:    rmux[7:0]  = acc_q;
            `AAD_OFS_STW:    rmux[7:0]  = stw_q;
            `AAD_OFS_PTR0:   rmux[7:0]  = ptr0_q;
            `AAD_OFS_PTR1:   rmux[7:0]  = ptr1_q;
            `AAD_OFS_INSTR:  rmux[15:0] = instr_q;
            `AAD_OFS_STATUS: rmux[1:0]  = {done_q, illegal_q};
            default:         rmux       = `AAD_RST_WORD;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= `AAD_RST_WORD;
      end else if (avs_read && wait_q) begin
         rdata_q <= rmux;
      end
   end

   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;
   assign acc_out         = acc_q;
   assign program_status_word_out = stw_q;

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   logic legal;
   assign legal = op != aad_pkg::AAD_OP_NONE;

   chk_dir_decode: assert property (
      exec && opc == 8'h25 |-> op == aad_pkg::AAD_OP_DIRECT)
      else $error("direct add opcode not decoded");

   chk_dir_sum: assert property (
      exec && op == aad_pkg::AAD_OP_DIRECT |=>
      acc_q == 8'($past(acc_q) + $past(operand)))
      else $error("direct add result wrong");

   chk_ind_sum: assert property (
      exec && op == aad_pkg::AAD_OP_INDIRECT |=>
      acc_q == 8'($past(acc_q) + $past(mem_q[ind_addr])
                  + {7'h00, $past(stw_q[7])}))
      else $error("indirect add with carry result wrong");

   chk_ind_ptr: assert property (
      exec && opc[7:1] == 7'h1b |->
      op == aad_pkg::AAD_OP_INDIRECT
      && operand == (opc[0] ? mem_q[ptr1_q] : mem_q[ptr0_q]))
      else $error("indirect pointer selection wrong");

   chk_keep_bank: assert property (
      exec |=> stw_q[5:3] == $past(stw_q[5:3])
               && stw_q[1] == $past(stw_q[1]))
      else $error("bank select or user flag disturbed");

   chk_carry_flag: assert property (
      exec && legal |=> stw_q[7] ==
      $past(({1'b0, acc_q} + {1'b0, operand} + {8'h00, cin}) > 9'h0ff))
      else $error("carry flag wrong");

   chk_parity_flag: assert property (
      exec && legal |=> stw_q[0] == ^acc_q)
      else $error("parity flag does not match accumulator");

   chk_no_illegal: assert property (
      exec && !legal |=> $stable(acc_q) && illegal_q)
      else $error("illegal opcode changed accumulator");

   chk_one_wait: assert property (
      req && wait_q |=> !wait_q ##1 wait_q)
      else $error("waitrequest not low for exactly one cycle");

   cov_dir: cover property (exec && op == aad_pkg::AAD_OP_DIRECT);
   cov_ind_cy: cover property (
      exec && op == aad_pkg::AAD_OP_INDIRECT && stw_q[7]);
   cov_carry_out: cover property (exec && legal && sum9[8]);
   cov_overflow: cover property (exec && legal && ovf);

endmodule

// >>> shared/aad_consts.svh
// register map, flag positions, opcodes and reset values of the adder
`ifndef AAD_CONSTS_SVH
`define AAD_CONSTS_SVH

// register byte offsets on the bus
`define AAD_OFS_ACC       11'h000
`define AAD_OFS_STW       11'h004
`define AAD_OFS_PTR0      11'h008
`define AAD_OFS_PTR1      11'h00c
`define AAD_OFS_INSTR     11'h010
`define AAD_OFS_STATUS    11'h014
`define AAD_OFS_MEM_BASE  11'h400

// program status word bit positions
`define AAD_SW_CARRY      3'h7
`define AAD_SW_AUX        3'h6
`define AAD_SW_USER0      3'h5
`define AAD_SW_BANK_HI    3'h4
`define AAD_SW_BANK_LO    3'h3
`define AAD_SW_OVFL       3'h2
`define AAD_SW_USER1      3'h1
`define AAD_SW_PARITY     3'h0

// opcodes
`define AAD_OP_ADD_DIR    8'h25
`define AAD_OP_ADC_IND    7'h1b

// status register bit positions
`define AAD_ST_ILLEGAL    5'h00
`define AAD_ST_DONE       5'h01

// reset values
`define AAD_RST_BYTE      8'h00
`define AAD_RST_INSTR     16'h0000
`define AAD_RST_WORD      32'h0000_0000

`endif

// >>> shared/aad_pkg.sv
// types shared by the accumulator adder
package aad_pkg;
   typedef logic [7:0] aad_byte_t;
   typedef enum logic [1:0] {
      AAD_OP_NONE,
      AAD_OP_DIRECT,
      AAD_OP_INDIRECT
   } aad_op_t;
endpackage

// >>> verification/test_accumulator_add_direct_indirect.sv
// self-checking bench for the accumulator add execution unit
`timescale 1ns/100ps
`include "aad_consts.svh"

module test_accumulator_add_direct_indirect;
   typedef struct packed {
      logic [7:0] op;
      logic [7:0] adr;
      logic [7:0] mem;
      logic [7:0] acc;
      logic [7:0] program_status_word;
      logic [7:0] eacc;
      logic [7:0] epsw;
   } aad_row_t;

   logic        ref_clk;
   logic        nrst;
   logic [10:0] avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [7:0]  acc_out;
   logic [7:0]  stw_out;
   logic [31:0] rd;
   int          mismatches;
   int          check_count;
   aad_row_t    rows [6];

   aad_core aad_core_i (
      .ref_clk         (ref_clk),
      .nrst            (nrst),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .acc_out         (acc_out),
      .program_status_word_out (stw_out)
   );

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp8(input string what, input logic [7:0] e,
                       input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic cmp32(input string what, input logic [31:0] e,
                        input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask

   // one idle edge first so a strobe is never driven twice in a step
   task automatic bus(input logic wr, input logic [10:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= ~wr;
      // no wait length assumed; the watchdog ends a hung request
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   function automatic logic [10:0] mem_ofs(input logic [7:0] adr);
      return `AAD_OFS_MEM_BASE + {1'b0, adr, 2'b00};
   endfunction

   task automatic do_reset();
      nrst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      @(negedge ref_clk);
      cmp8("acc_out reset", 8'h00, acc_out);
      cmp8("stw_out reset", 8'h00, stw_out);
      cmp8("waitrequest reset", 8'h01, {7'h00, avs_waitrequest});
      $display("reset test done");
   endtask

   initial begin
      #20000;
      mismatches++;
      $display("BAD watchdog expected finish seen timeout");
      summarize();
   end

   initial begin
      nrst = 1'b0;
      avs_address = 11'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      mismatches = 0;
      check_count = 0;
      // op, address, memory byte, acc, psw before, acc and psw after
      rows = '{'{8'h25, 8'h90, 8'hc6, 8'h72, 8'h00, 8'h38, 8'h81},
               '{8'h25, 8'h45, 8'h01, 8'h7f, 8'hba, 8'h80, 8'h7f},
               '{8'h36, 8'h6b, 8'h0f, 8'hf0, 8'h80, 8'h00, 8'hc0},
               '{8'h37, 8'hff, 8'h80, 8'h80, 8'h3a, 8'h00, 8'hbe},
               '{8'h36, 8'h00, 8'h22, 8'h11, 8'h01, 8'h33, 8'h00},
               '{8'h37, 8'h7f, 8'h3f, 8'h40, 8'h80, 8'h80, 8'h45}};
      do_reset();
      foreach (rows[i]) begin
         // decoy byte behind the pointer that must not be used
         bus(1'b1, mem_ofs(rows[i].adr + 8'h01), {24'h0, ~rows[i].mem});
         bus(1'b1, mem_ofs(rows[i].adr), {24'h0, rows[i].mem});
         bus(1'b1, `AAD_OFS_PTR0, {24'h0, rows[i].op[0] ?
             rows[i].adr + 8'h01 : rows[i].adr});
         bus(1'b1, `AAD_OFS_PTR1, {24'h0, rows[i].op[0] ?
             rows[i].adr : rows[i].adr + 8'h01});
         bus(1'b1, `AAD_OFS_ACC, {24'h0, rows[i].acc});
         bus(1'b1, `AAD_OFS_STW, {24'h0, rows[i].program_status_word});
         bus(1'b1, `AAD_OFS_INSTR,
             {16'h0, rows[i].adr, rows[i].op});
         @(negedge ref_clk);
         cmp8("acc_out", rows[i].eacc, acc_out);
         cmp8("stw_out", rows[i].epsw, stw_out);
         bus(1'b0, `AAD_OFS_ACC, 32'h0);
         cmp32("acc readback", {24'h0, rows[i].eacc}, rd);
         bus(1'b0, `AAD_OFS_STW, 32'h0);
         cmp32("stw readback", {24'h0, rows[i].epsw}, rd);
         $display("row %0d done", i);
      end
      // two adds back to back accumulate
      bus(1'b1, mem_ofs(8'h10), 32'h0000_0001);
      bus(1'b1, `AAD_OFS_ACC, 32'h0000_0001);
      bus(1'b1, `AAD_OFS_INSTR, 32'h0000_1025);
      bus(1'b1, `AAD_OFS_INSTR, 32'h0000_1025);
      @(negedge ref_clk);
      cmp8("acc_out chained", 8'h03, acc_out);
      cmp8("stw_out chained", 8'h00, stw_out);
      $display("chained test done");
      // neighbour opcode is not an add here: acc and psw may not change, illegal is flagged
      bus(1'b1, `AAD_OFS_INSTR, 32'h0000_1024);
      @(negedge ref_clk);
      cmp8("acc_out illegal", 8'h03, acc_out);
      cmp8("stw_out illegal", 8'h00, stw_out);
      bus(1'b0, `AAD_OFS_INSTR, 32'h0);
      cmp32("instr readback", 32'h0000_1024, rd);
      bus(1'b0, `AAD_OFS_STATUS, 32'h0);
      cmp32("status illegal", 32'h0000_0001, rd & 32'h0000_0001);
      bus(1'b1, `AAD_OFS_STATUS, 32'h0000_0003);
      bus(1'b0, `AAD_OFS_STATUS, 32'h0);
      cmp32("status cleared", 32'h0000_0000, rd);
      bus(1'b0, 11'h018, 32'h0);
      cmp32("unmapped read", 32'h0000_0000, rd);
      $display("illegal and unmapped test done");
      do_reset();
      summarize();
   end
endmodule
